// [design/ddpu_top.sv]
// Purpose: Dual data pointer unit with control register and post-adjust.
// Assumes: Sequencer pulses move_ptr only for moves addressed through the pointer.
// Notes: Pointer byte writes and loads always hit the active pointer.
//
// Operation
// - Select 0 makes main pointer active.
// - Select 1 makes shadow pointer active.
// - Auto-swap inverts select after each move.
// - Shadow mode: keep, increment, decrement, toggle.
// - Main mode: keep, increment, decrement, toggle.
// - Only pointer-addressed moves adjust pointer.
// - Other pointer uses target the active one.
// - Control bits 7 and 1 unimplemented.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module ddpu_top #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic move_ptr,
    input wire logic load_ptr,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] active_pointer
);
    logic [7:0] pointer_control_reg;
    logic [WIDTH-1:0] main_ptr;
    logic [WIDTH-1:0] shadow_ptr;
    logic [WIDTH-1:0] main_adj;
    logic [WIDTH-1:0] shadow_adj;
    logic [WIDTH-1:0] next_main;
    logic [WIDTH-1:0] next_shadow;
    logic [WIDTH-1:0] next_active;
    logic [7:0] next_control;
    logic [7:0] read_mux;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire pointer_select = pointer_control_reg[ddpu_pkg::BIT_SELECT];
    wire auto_swap_enable = pointer_control_reg[ddpu_pkg::BIT_AUTO_SWAP];
    wire [1:0] main_mode = pointer_control_reg[ddpu_pkg::BIT_MAIN_MODE_LO +: 2];
    wire [1:0] shadow_mode = pointer_control_reg[ddpu_pkg::BIT_SHADOW_MODE_LO +: 2];
    wire wr_control = wr && (addr == ddpu_pkg::ADDR_CONTROL);
    wire wr_low = wr && (addr == ddpu_pkg::ADDR_PTR_LOW);
    wire wr_high = wr && (addr == ddpu_pkg::ADDR_PTR_HIGH);
    wire [7:0] pointer_low_byte = active_pointer[7:0];
    wire [7:0] pointer_high_byte = active_pointer[15:8];

    assign active_pointer = pointer_select ? shadow_ptr : main_ptr;

    ddpu_adjust #(.WIDTH(WIDTH)) u_main_adj (
        .value(main_ptr),
        .mode(main_mode),
        .adjusted(main_adj)
    );
    ddpu_adjust #(.WIDTH(WIDTH)) u_shadow_adj (
        .value(shadow_ptr),
        .mode(shadow_mode),
        .adjusted(shadow_adj)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // A move adjusts only the active pointer; software accesses then override.
    always_comb begin
        next_active = active_pointer;
        if (move_ptr) begin
            next_active = pointer_select ? shadow_adj : main_adj;
        end
        if (load_ptr) begin
            next_active = load_value;
        end
        if (wr_low) begin
            next_active[7:0] = wdata;
        end
        if (wr_high) begin
            next_active[15:8] = wdata;
        end
        next_main = pointer_select ? main_ptr : next_active;
        next_shadow = pointer_select ? next_active : shadow_ptr;
        next_control = pointer_control_reg;
        if (move_ptr && auto_swap_enable) begin
            next_control[ddpu_pkg::BIT_SELECT] = ~pointer_select;
        end
        if (wr_control) begin
            next_control = wdata & ddpu_pkg::CONTROL_WMASK;
        end
    end

    always_comb begin
        case (addr)
            ddpu_pkg::ADDR_CONTROL: read_mux = pointer_control_reg;
            ddpu_pkg::ADDR_PTR_LOW: read_mux = pointer_low_byte;
            ddpu_pkg::ADDR_PTR_HIGH: read_mux = pointer_high_byte;
            default: read_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pointer_control_reg <= ddpu_pkg::CONTROL_RESET;
            main_ptr <= ddpu_pkg::POINTER_RESET;
            shadow_ptr <= ddpu_pkg::POINTER_RESET;
            rdata <= 8'h00;
        end else begin
            pointer_control_reg <= next_control;
            main_ptr <= next_main;
            shadow_ptr <= next_shadow;
            rdata <= rd ? read_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // A plain move has no software access in the same cycle, so only the
    // adjustment and the swap may change the registers.
    sequence s_plain_move;
        move_ptr && !load_ptr && !wr_low && !wr_high && !wr_control;
    endsequence

    sequence s_main_move;
        s_plain_move ##0 !pointer_select;
    endsequence

    sequence s_shadow_move;
        s_plain_move ##0 pointer_select;
    endsequence

    // ------------------------------------------------------------
    // Selection and swap assertions
    // ------------------------------------------------------------
    a_active_mux: assert property (@(posedge clk_sys) disable iff (!nrst)
        active_pointer == (pointer_select ? shadow_ptr : main_ptr))
        else $error("active pointer not selected by select bit");
    a_shadow_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
        !pointer_select |=> $stable(shadow_ptr))
        else $error("inactive shadow pointer changed");
    a_main_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
        pointer_select |=> $stable(main_ptr))
        else $error("inactive main pointer changed");
    a_swap_move: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_plain_move ##0 auto_swap_enable) |=> pointer_select != $past(pointer_select))
        else $error("auto swap did not invert select");
    a_no_swap: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!auto_swap_enable && !wr_control) |=> $stable(pointer_select))
        else $error("select changed without auto swap");
    a_swap_fields: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_plain_move |=> $stable(main_mode) && $stable(shadow_mode)
        && $stable(auto_swap_enable))
        else $error("move changed control fields other than select");

    // ------------------------------------------------------------
    // Adjustment assertions
    // ------------------------------------------------------------
    a_shadow_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_shadow_move ##0 shadow_mode == ddpu_pkg::DDPU_MODE_KEEP)
        |=> $stable(shadow_ptr))
        else $error("shadow keep mode changed pointer");
    a_shadow_inc: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_shadow_move ##0 shadow_mode == ddpu_pkg::DDPU_MODE_INC)
        |=> shadow_ptr == $past(shadow_ptr) + 16'h0001)
        else $error("shadow increment wrong");
    a_shadow_dec: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_shadow_move ##0 shadow_mode == ddpu_pkg::DDPU_MODE_DEC)
        |=> shadow_ptr == $past(shadow_ptr) - 16'h0001)
        else $error("shadow decrement wrong");
    a_shadow_toggle: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_shadow_move ##0 shadow_mode == ddpu_pkg::DDPU_MODE_TOGGLE)
        |=> shadow_ptr == ($past(shadow_ptr) ^ 16'h0001))
        else $error("shadow toggle wrong");
    a_main_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_main_move ##0 main_mode == ddpu_pkg::DDPU_MODE_KEEP)
        |=> $stable(main_ptr))
        else $error("main keep mode changed pointer");
    a_main_inc: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_main_move ##0 main_mode == ddpu_pkg::DDPU_MODE_INC)
        |=> main_ptr == $past(main_ptr) + 16'h0001)
        else $error("main increment wrong");
    a_main_dec: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_main_move ##0 main_mode == ddpu_pkg::DDPU_MODE_DEC)
        |=> main_ptr == $past(main_ptr) - 16'h0001)
        else $error("main decrement wrong");
    a_main_toggle: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_main_move ##0 main_mode == ddpu_pkg::DDPU_MODE_TOGGLE)
        |=> main_ptr == ($past(main_ptr) ^ 16'h0001))
        else $error("main toggle wrong");
    a_no_move_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!move_ptr && !load_ptr && !wr_low && !wr_high)
        |=> $stable(active_pointer) || $past(wr_control))
        else $error("pointer changed without move or write");

    // ------------------------------------------------------------
    // Software access assertions
    // ------------------------------------------------------------
    a_load_active: assert property (@(posedge clk_sys) disable iff (!nrst)
        (load_ptr && !wr_low && !wr_high && !pointer_select) |=> main_ptr == $past(load_value))
        else $error("load missed active pointer");
    a_load_shadow: assert property (@(posedge clk_sys) disable iff (!nrst)
        (load_ptr && !wr_low && !wr_high && pointer_select)
        |=> shadow_ptr == $past(load_value))
        else $error("load missed shadow pointer");
    a_write_low: assert property (@(posedge clk_sys) disable iff (!nrst)
        (wr_low && !pointer_select) |=> main_ptr[7:0] == $past(wdata))
        else $error("low byte write missed main pointer");
    a_write_high: assert property (@(posedge clk_sys) disable iff (!nrst)
        (wr_high && pointer_select) |=> shadow_ptr[15:8] == $past(wdata))
        else $error("high byte write missed shadow pointer");
    a_unimpl_bits: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pointer_control_reg & ~ddpu_pkg::CONTROL_WMASK) == 8'h00)
        else $error("unimplemented control bit set");
    a_control_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_control |=> pointer_control_reg == ($past(wdata) & ddpu_pkg::CONTROL_WMASK))
        else $error("control write not masked");

    // ------------------------------------------------------------
    // Read port assertions
    // ------------------------------------------------------------
    a_read_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
        !rd |=> rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_read_control: assert property (@(posedge clk_sys) disable iff (!nrst)
        (rd && addr == ddpu_pkg::ADDR_CONTROL)
        |=> rdata == $past(pointer_control_reg)
        && (rdata & ~ddpu_pkg::CONTROL_WMASK) == 8'h00)
        else $error("control read wrong");
    a_read_low: assert property (@(posedge clk_sys) disable iff (!nrst)
        (rd && addr == ddpu_pkg::ADDR_PTR_LOW && !pointer_select)
        |=> rdata == 8'($past(main_ptr)))
        else $error("low byte read does not show main pointer");
    a_read_high: assert property (@(posedge clk_sys) disable iff (!nrst)
        (rd && addr == ddpu_pkg::ADDR_PTR_HIGH && pointer_select)
        |=> rdata == 8'($past(shadow_ptr) >> 8))
        else $error("high byte read does not show shadow pointer");
endmodule

// [design/ddpu_pkg.sv]
// Purpose: Constants shared by the dual data pointer unit.
// Assumes: Byte-wide special register port with 8-bit addresses.
// Notes: Offsets are the core's special register addresses.
package ddpu_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'ha7;
    localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
    localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'h7d;
    localparam int BIT_SELECT = 0;
    localparam int BIT_MAIN_MODE_LO = 2;
    localparam int BIT_SHADOW_MODE_LO = 4;
    localparam int BIT_AUTO_SWAP = 6;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    typedef enum logic [1:0] {
        DDPU_MODE_KEEP = 2'h0,
        DDPU_MODE_INC = 2'h1,
        DDPU_MODE_DEC = 2'h2,
        DDPU_MODE_TOGGLE = 2'h3
    } ddpu_mode_t;
endpackage

// [design/ddpu_adjust.sv]
// Purpose: Next value of one pointer after a qualifying move.
// Assumes: Purely combinational.
// Notes: Wraps modulo the pointer width.
`timescale 1ns/1ps
module ddpu_adjust #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] value,
    input wire logic [1:0] mode,
    output logic [WIDTH-1:0] adjusted
);
    always_comb begin
        case (mode)
            ddpu_pkg::DDPU_MODE_INC: adjusted = value + {{(WIDTH-1){1'b0}}, 1'b1};
            ddpu_pkg::DDPU_MODE_DEC: adjusted = value - {{(WIDTH-1){1'b0}}, 1'b1};
            ddpu_pkg::DDPU_MODE_TOGGLE: adjusted = {value[WIDTH-1:1], ~value[0]};
            default: adjusted = value;
        endcase
    end
endmodule

// [tb/ddpu_seq_model.sv]
// Purpose: Sequencer stand-in that pulses pointer moves and loads.
// Assumes: Each pulse lasts one clock.
// Notes: The load value idles at the inverse of the last value.
`timescale 1ns/1ps
module ddpu_seq_model (
    input wire logic clk_sys,
    output logic move_ptr,
    output logic load_ptr,
    output logic [15:0] load_value
);
    initial begin
        move_ptr = 1'b0;
        load_ptr = 1'b0;
        load_value = 16'h0000;
    end
    task automatic pulse(input logic m, input logic l, input logic [15:0] v);
        @(posedge clk_sys);
        move_ptr <= m;
        load_ptr <= l;
        load_value <= v;
        @(posedge clk_sys);
        move_ptr <= 1'b0;
        load_ptr <= 1'b0;
        load_value <= ~v;
    endtask
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench for the dual data pointer unit.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: Moves and loads come from the sequencer model.
`timescale 1ns/1ps
module testbench;
    logic clk_sys, nrst, wr, rd, move_ptr, load_ptr;
    logic [7:0] addr, wdata, rdata;
    logic [15:0] load_value, active_pointer;
    int bad_count = 0;
    int compares = 0;
    ddpu_top #(.WIDTH(16)) i_ddpu_top (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .move_ptr(move_ptr),
        .load_ptr(load_ptr), .load_value(load_value), .active_pointer(active_pointer));
    ddpu_seq_model i_ddpu_seq_model (.clk_sys(clk_sys), .move_ptr(move_ptr),
        .load_ptr(load_ptr), .load_value(load_value));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic mv(input logic [15:0] e);
        i_ddpu_seq_model.pulse(1'b1, 1'b0, 16'h0000);
        #1 chk(active_pointer, e);
    endtask
    function automatic logic [15:0] adj(input logic [15:0] p, input logic [1:0] m);
        return (m == 2'h1) ? p + 16'h0001 : (m == 2'h2) ? p - 16'h0001 :
            (m == 2'h3) ? p ^ 16'h0001 : p;
    endfunction
    task automatic finish_test;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys);
        bad_count++;
        finish_test;
    end
    initial begin
        {nrst, wr, rd, addr, wdata} = '0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        rd_chk(ddpu_pkg::ADDR_CONTROL, 8'h00);
        wr_reg(ddpu_pkg::ADDR_CONTROL, 8'hff);
        rd_chk(ddpu_pkg::ADDR_CONTROL, 8'h7d);
        rd_chk(8'h90, 8'h00);
        $display("test control_register done");
        wr_reg(ddpu_pkg::ADDR_CONTROL, 8'h00);
        wr_reg(ddpu_pkg::ADDR_PTR_LOW, 8'h34);
        wr_reg(ddpu_pkg::ADDR_PTR_HIGH, 8'h12);
        wr_reg(ddpu_pkg::ADDR_CONTROL, 8'h01);
        wr_reg(ddpu_pkg::ADDR_PTR_LOW, 8'hcd);
        wr_reg(ddpu_pkg::ADDR_PTR_HIGH, 8'hab);
        rd_chk(ddpu_pkg::ADDR_PTR_HIGH, 8'hab);
        wr_reg(ddpu_pkg::ADDR_CONTROL, 8'h00);
        rd_chk(ddpu_pkg::ADDR_PTR_LOW, 8'h34);
        chk(active_pointer, 16'h1234);
        $display("test pointer_select done");
        for (int m = 0; m < 4; m++) begin
            wr_reg(ddpu_pkg::ADDR_CONTROL, 8'(m << 2));
            i_ddpu_seq_model.pulse(1'b0, 1'b1, 16'hffff);
            #1 chk(active_pointer, 16'hffff);
            mv(adj(16'hffff, 2'(m)));
            wr_reg(ddpu_pkg::ADDR_CONTROL, 8'(m << 4) | 8'h01);
            i_ddpu_seq_model.pulse(1'b0, 1'b1, 16'h0000);
            mv(adj(16'h0000, 2'(m)));
        end
        rd_chk(ddpu_pkg::ADDR_CONTROL, 8'h31);
        $display("test adjust_modes done");
        i_ddpu_seq_model.pulse(1'b0, 1'b1, 16'h2000);
        wr_reg(ddpu_pkg::ADDR_CONTROL, 8'h00);
        i_ddpu_seq_model.pulse(1'b0, 1'b1, 16'h1000);
        wr_reg(ddpu_pkg::ADDR_CONTROL, 8'h55);
        mv(16'h1000);
        mv(16'h2001);
        rd_chk(ddpu_pkg::ADDR_CONTROL, 8'h55);
        $display("test auto_swap done");
        finish_test;
    end
endmodule
